// *** dol_regs.svh ***
`ifndef DOL_REGS_SVH
`define DOL_REGS_SVH

// ------------------------------------------------------------------
// Register map
// ------------------------------------------------------------------
`define DOL_ADDR_STATUS   2'h0
`define DOL_ADDR_MASK     2'h1
`define DOL_ADDR_STATE    2'h2

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define DOL_EV_GAINED     0
`define DOL_EV_LOST       1

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define DOL_STATUS_RST    2'h0
`define DOL_MASK_RST      2'h0

// ------------------------------------------------------------------
// Framing and timing counts
// ------------------------------------------------------------------
`define DOL_FRAME_LAST    4'hB
`define DOL_RCLK_FALL     4'h6
`define DOL_LOCK_GOOD     3'h4
`define DOL_LOSS_BAD      3'h4

`endif

// *** dol_pkg.sv ***
package dol_pkg;

   // Complete state of the lock control block.
   typedef struct packed {
      logic [11:0] shift;
      logic [3:0]  phase;
      logic        locked;
      logic [2:0]  good_cnt;
      logic [2:0]  bad_cnt;
      logic [9:0]  word;
      logic [9:0]  data;
      logic        rclk;
      logic        data_oe;
      logic        rclk_oe;
      logic        lock_n;
      logic        lock_oe;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic [7:0]  rdata;
      logic        irq;
   } dol_state_t;

   // Software port.
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dol_bus_t;

endpackage

// *** dol_lock_ctrl.sv ***
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "dol_regs.svh"
// Operation
// (R1) Edge select high strobes data on recovered clock rise, low on its fall.
// (R2) Power-down low stops recovery and floats data, lock and clock outputs.
// (R3) Active-low lock output is low when locked, high when not.
// (R4) Recovered clock runs at word rate and strobes the parallel data.
// (R5) Output enable low floats data and recovered clock outputs.
// (R6) When powered and enabled, lock output follows current lock state.
// (R7) Recovered clock toggles only while locked.
// (R8) While unlocked, data and recovered clock outputs float.
// (R9) Locks to arbitrary framed traffic without sync patterns.
// (R10) System supplies a running reference clock for recovery.
// (R11) Lock is lost only after four consecutive invalid frames.
// (R12) After relock, up to three words before loss are suspect.
// (R13) Serializer may use lock output as its sync request.
// (R14) Reference clock must run before lock can be achieved.
// (R15) While locked and enabled, data updates once per recovered clock period.
module dol_lock_ctrl (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                serial_in_p,
   input  wire logic                serial_in_n,
   input  wire logic                power_down_n,
   input  wire logic                output_enable,
   input  wire logic                strobe_edge_sel,
   input  wire dol_pkg::dol_bus_t   bus,
   output logic [9:0]               par_data_out,
   output logic                     par_data_oe,
   output logic                     rclk_out,
   output logic                     rclk_oe,
   output logic                     lock_n,
   output logic                     lock_oe,
   output logic [7:0]               rdata,
   output logic                     irq
);

   dol_pkg::dol_state_t q_reg;
   dol_pkg::dol_state_t q_next;
   logic                rx_bit;
   logic                frame_ok;
   logic                frame_end;
   logic [1:0]          ev_set;
   logic [1:0]          ev_clr;

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------

   // The clk_sys domain stands in for the reference-clock driven
   // recovery loop, so serial bits are sampled one per edge.
   always_comb begin
      q_next    = q_reg;
      rx_bit    = serial_in_p & ~serial_in_n;
      ev_set    = 2'h0;
      ev_clr    = 2'h0;
      frame_end = (q_reg.phase == `DOL_FRAME_LAST);
      q_next.shift = {q_reg.shift[10:0], rx_bit};
      // Each frame carries a high start bit and a low stop bit.
      frame_ok  = q_next.shift[11] & ~q_next.shift[0];
      q_next.phase = frame_end ? 4'h0 : q_reg.phase + 4'h1;
      if (frame_end) begin
         if (!q_reg.locked) begin
            // Hunt over any traffic: a bad frame slips alignment one bit.
            if (frame_ok) begin
               q_next.good_cnt = q_reg.good_cnt + 3'h1; // R9
               if (q_next.good_cnt == `DOL_LOCK_GOOD) begin
                  q_next.locked  = 1'b1;
                  q_next.bad_cnt = 3'h0;
                  ev_set[`DOL_EV_GAINED] = 1'b1;
               end
            end else begin
               q_next.good_cnt = 3'h0;
               q_next.phase    = q_reg.phase; // R9
            end
         end else begin
            // Words stay captured while loss is pending; they may be bad.
            q_next.word = q_next.shift[10:1];
            if (frame_ok) begin
               q_next.bad_cnt = 3'h0;
            end else begin
               q_next.bad_cnt = q_reg.bad_cnt + 3'h1;
               if (q_next.bad_cnt == `DOL_LOSS_BAD) begin
                  q_next.locked   = 1'b0; // R11
                  q_next.good_cnt = 3'h0;
                  ev_set[`DOL_EV_LOST] = 1'b1;
               end
            end
         end
      end
      // Power-down holds the recovery logic idle.
      if (!power_down_n) begin
         q_next.locked   = 1'b0; // R2
         q_next.good_cnt = 3'h0;
         q_next.bad_cnt  = 3'h0;
         q_next.phase    = 4'h0;
         if (q_reg.locked) begin
            ev_set[`DOL_EV_LOST] = 1'b1;
         end
      end
      // Recovered clock: high in the first half of each word period.
      q_next.rclk = q_next.locked & (q_next.phase < `DOL_RCLK_FALL); // R4 R7
      // Data changes on the opposite edge so it is stable on the chosen one.
      if (q_next.locked) begin
         if (strobe_edge_sel ? (q_next.phase == `DOL_RCLK_FALL)
                             : (q_next.phase == 4'h0)) begin
            q_next.data = q_next.word; // R1 R15
         end
      end
      q_next.data_oe = power_down_n & output_enable & q_next.locked; // R2 R5 R8
      q_next.rclk_oe = power_down_n & output_enable & q_next.locked; // R5 R8
      // Lock stays driven with output enable low; only power-down and reset float it.
      q_next.lock_oe = power_down_n; // R2 R6
      q_next.lock_n  = ~q_next.locked; // R3 R6
      // Register port; a hardware event wins over a clearing write.
      q_next.rdata = 8'h00;
      if (bus.wr && bus.addr == `DOL_ADDR_STATUS) begin
         ev_clr = bus.wdata[1:0];
      end
      if (bus.wr && bus.addr == `DOL_ADDR_MASK) begin
         q_next.mask = bus.wdata[1:0];
      end
      q_next.status = (q_reg.status & ~ev_clr) | ev_set;
      if (bus.rd) begin
         unique case (bus.addr)
            `DOL_ADDR_STATUS: q_next.rdata = {6'h00, q_reg.status};
            `DOL_ADDR_MASK:   q_next.rdata = {6'h00, q_reg.mask};
            `DOL_ADDR_STATE:  q_next.rdata = {5'h00, strobe_edge_sel,
                                              power_down_n, q_reg.locked};
            default:          q_next.rdata = 8'h00;
         endcase
      end
      q_next.irq = |(q_next.status & q_next.mask);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------

   // Synchronous reset; lock indicator rests high (not locked).
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q_reg        <= '0;
         q_reg.lock_n <= 1'b1;
         q_reg.status <= `DOL_STATUS_RST;
         q_reg.mask   <= `DOL_MASK_RST;
      end else begin
         q_reg <= q_next;
      end
   end

   // Outputs straight from the state flip-flops.
   assign par_data_out = q_reg.data;
   assign par_data_oe  = q_reg.data_oe;
   assign rclk_out     = q_reg.rclk;
   assign rclk_oe      = q_reg.rclk_oe;
   assign lock_n       = q_reg.lock_n;
   assign lock_oe      = q_reg.lock_oe;
   assign rdata        = q_reg.rdata;
   assign irq          = q_reg.irq;

endmodule

// *** dol_lock_ctrl_monitor.sv ***
`timescale 1ns/10ps
// ------
// Port checks.
// ------
module dol_lock_ctrl_monitor (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              serial_in_p,
   input wire logic              serial_in_n,
   input wire logic              power_down_n,
   input wire logic              output_enable,
   input wire logic              strobe_edge_sel,
   input wire dol_pkg::dol_bus_t bus,
   input wire logic [9:0]        par_data_out,
   input wire logic              par_data_oe,
   input wire logic              rclk_out,
   input wire logic              rclk_oe,
   input wire logic              lock_n,
   input wire logic              lock_oe,
   input wire logic [7:0]        rdata,
   input wire logic              irq
);
   // Locked, powered and enabled; outputs may lag this by a register stage.
   wire on = !lock_n && output_enable && power_down_n;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   pd_float_a: assert property (!power_down_n |=> !par_data_oe && !rclk_oe && !lock_oe)
      else $error("driven in power-down");
   oe_float_a: assert property (!output_enable |=> !par_data_oe && !rclk_oe)
      else $error("driven while disabled");
   unlock_float_a: assert property (lock_n && $past(lock_n) |-> !par_data_oe && !rclk_oe)
      else $error("driven while unlocked");
   rclk_idle_a: assert property (lock_n && $past(lock_n) |-> $stable(rclk_out))
      else $error("clock runs unlocked");
   rclk_half_a: assert property ($rose(rclk_out) |-> (rclk_out || lock_n)[*6] ##1 (!rclk_out || lock_n))
      else $error("clock period wrong");
   out_driven_a: assert property (on && $past(on) && $past(on, 2) |-> par_data_oe && rclk_oe)
      else $error("outputs not driven");
   lock_kept_a: assert property (power_down_n && $past(power_down_n) && !$past(rst) |-> lock_oe)
      else $error("lock not driven");
   data_edge_a: assert property ($changed(par_data_out) && par_data_oe && $past(par_data_oe)
      && $stable(strobe_edge_sel) |-> (strobe_edge_sel ? $fell(rclk_out) : $rose(rclk_out)))
      else $error("data on wrong edge");
   cover property (!lock_n && par_data_oe);
   cover property ($rose(lock_n));
   cover property (irq);
endmodule

bind dol_lock_ctrl dol_lock_ctrl_monitor i_dol_lock_ctrl_monitor (.*);

// *** dol_serializer_model.sv ***
`timescale 1ns/10ps
// ------
// Serializer model.
// ------
module dol_serializer_model (
   input  wire logic clk_sys,
   input  wire logic corrupt,
   output logic      serial_in_p,
   output logic      serial_in_n
);
   logic [3:0]  idx = 4'h0;
   logic [9:0]  word = 10'h000;
   wire  [11:0] frame = {1'b1, word, corrupt};
   // Thermometer words give one start position only, so a false lock cannot happen.
   always_ff @(posedge clk_sys) begin
      idx <= (idx == 4'hB) ? 4'h0 : idx + 4'h1;
      if (idx == 4'hB) word <= (word == 10'h3FF) ? 10'h000 : {1'b1, word[9:1]};
   end
   // Start 1, word MSB first, stop 0; a corrupt frame breaks its stop bit.
   assign serial_in_p = frame[4'hB - idx];
   assign serial_in_n = ~serial_in_p;
endmodule

// *** dol_lock_ctrl_tb.sv ***
`timescale 1ns/10ps
// ------
// Testbench.
// ------
module dol_lock_ctrl_tb;
   logic clk_sys = 1'b0, rst = 1'b1, power_down_n = 1'b1, output_enable = 1'b1;
   logic strobe_edge_sel = 1'b1, corrupt = 1'b0, serial_in_p, serial_in_n;
   logic par_data_oe, rclk_out, rclk_oe, lock_n, lock_oe, irq;
   logic [9:0] par_data_out, v;
   logic [7:0] rdata;
   dol_pkg::dol_bus_t bus = '0;
   int miscompares = 0, n_tests = 0;
   dol_lock_ctrl i_dol_lock_ctrl (.*);
   // The thermometer stream acts as a standing sync pattern, as if lock_n drove the request.
   dol_serializer_model i_dol_serializer_model (.clk_sys(clk_sys), .corrupt(corrupt),
      .serial_in_p(serial_in_p), .serial_in_n(serial_in_n));
   // The system clock also serves as reference clock and runs before reset ends.
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One bus cycle; read data are checked in the cycle after the strobe.
   task automatic acc(input logic rd, input logic [1:0] a, input logic [7:0] d);
      bus <= '{a, d, !rd, rd};
      @(posedge clk_sys);
      bus <= '0;
      @(negedge clk_sys);
      if (rd) chk(rdata, d);
      @(posedge clk_sys);
   endtask
   // Bounded wait; random lock may need many slips first.
   task automatic wl(input logic want);
      for (int i = 0; i < 600 && lock_n !== want; i++) @(posedge clk_sys);
      chk(lock_n, want);
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk({lock_n, par_data_oe}, 2'b10);
      acc(1, 2'h3, 8'h00);
      acc(0, 2'h1, 8'h03);
      wl(1'b0);
      repeat (3) @(posedge clk_sys);
      chk(irq, 1'b1);
      acc(1, 2'h2, 8'h07);
      acc(0, 2'h0, 8'h01);
      acc(1, 2'h0, 8'h00);
      chk(irq, 1'b0);
      for (int e = 1; e >= 0; e--) begin
         strobe_edge_sel <= e[0];
         repeat (2) @(par_data_out);
         v = par_data_out;
         @(par_data_out);
         chk(par_data_out, (v === 10'h3FF) ? 10'h000 : {1'b1, v[9:1]});
      end
      output_enable <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({par_data_oe, rclk_oe, lock_oe}, 3'b001);
      output_enable <= 1'b1;
      corrupt <= 1'b1;
      repeat (36) @(posedge clk_sys);
      chk(lock_n, 1'b0);
      wl(1'b1);
      acc(1, 2'h0, 8'h02);
      corrupt <= 1'b0;
      // Words around the loss are suspect, so no data compare spans the relock.
      wl(1'b0);
      power_down_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({par_data_oe, rclk_oe, lock_oe}, 3'b000);
      acc(1, 2'h0, 8'h03);
      print_verdict();
   end
   // The tests need a few hundred cycles; twenty thousand means a hang.
   initial begin
      #2000000;
      miscompares++;
      print_verdict();
   end
endmodule
